/* File: core/oag_cfg.svh */
// constants for the operand address generator
`ifndef OAG_CFG_SVH
`define OAG_CFG_SVH
`define STEP_BYTE 16'h0001
`define STEP_WORD 16'h0002
`define SP_NUM 3'h6
`define PC_NUM 3'h7
`define REG_RESET 16'h0000
`define BYTE_LSB 0
`define BYTE_MSB 7
`define MODE_LSB 3
`define MODE_MSB 5
`define REG_LSB 0
`define REG_MSB 2
`endif

/* File: core/oag_pkg.sv */
// types for the operand address generator
package oag_pkg;
  typedef logic [15:0] word_t;
  typedef enum logic [2:0] {
    AM_REG = 3'h0,
    AM_REGDEF = 3'h1,
    AM_AUTOINC = 3'h2,
    AM_AUTOINCDEF = 3'h3,
    AM_AUTODEC = 3'h4,
    AM_AUTODECDEF = 3'h5,
    AM_INDEX = 3'h6,
    AM_INDEXDEF = 3'h7
  } addr_mode_t;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_INDEX = 4'b0010,
    ST_DEFER = 4'b0100,
    ST_DONE = 4'b1000
  } state_t;
endpackage : oag_pkg

/* File: core/oag_if.sv */
// bundle between the operand address generator and the register step calculator
`timescale 1ns/10ps
interface oag_if;
  import oag_pkg::*;
  addr_mode_t mode;
  logic [2:0] reg_num;
  logic byte_op;
  word_t sel_value;
  word_t step;
  word_t next_value;
  word_t pointer;
  modport calc (input mode, input reg_num, input byte_op, input sel_value,
                output step, output next_value, output pointer);
  modport user (output mode, output reg_num, output byte_op, output sel_value,
                input step, input next_value, input pointer);
endinterface : oag_if

/* File: core/ea_step_unit.sv */
// register step and first pointer for the autoincrement and autodecrement modes
`timescale 1ns/10ps
`include "oag_cfg.svh"
module ea_step_unit
  import oag_pkg::*;
(
  oag_if.calc bus
);
  wire stepped_mode = (bus.mode == AM_AUTOINC) || (bus.mode == AM_AUTODEC);
  wire is_dec = (bus.mode == AM_AUTODEC) || (bus.mode == AM_AUTODECDEF);
  wire is_inc = (bus.mode == AM_AUTOINC) || (bus.mode == AM_AUTOINCDEF);
  // stack pointer and program counter always step by two
  // deferred modes step by two even for bytes
  assign bus.step = (bus.byte_op && stepped_mode && (bus.reg_num < `SP_NUM)) ?
                    `STEP_BYTE : `STEP_WORD;
  // sums wrap at 16 bits with no flag
  assign bus.next_value = is_inc ? 16'(bus.sel_value + bus.step) :
                          is_dec ? 16'(bus.sel_value - bus.step) :
                          bus.sel_value;
  // post-increment uses the old value, pre-decrement the new one
  assign bus.pointer = is_dec ? bus.next_value : bus.sel_value;
endmodule : ea_step_unit

/* File: core/operand_address_generator.sv */
// operand address generator with its general register file
`timescale 1ns/10ps
`include "oag_cfg.svh"
module operand_address_generator
  import oag_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // operand request from the sequencer
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [5:0] req_spec,
  input wire logic req_byte,
  // resolved operand
  output logic done,
  output logic opnd_is_reg,
  output logic [2:0] opnd_reg,
  output word_t opnd_addr,
  // word reads from memory
  output logic mem_rd_req,
  output word_t mem_addr,
  input wire logic mem_rd_ack,
  input wire word_t mem_rd_data,
  // result written back to a register
  input wire logic res_we,
  input wire logic [2:0] res_reg,
  input wire logic res_byte,
  input wire logic res_byte_move,
  input wire word_t res_data,
  // instruction word fetched by the sequencer
  input wire logic pc_step,
  // register read port
  input wire logic [2:0] rd_sel,
  output word_t rd_data
);
  word_t regs [0:7];
  state_t state;
  state_t next_state;
  addr_mode_t mode_q;

  // specifier decode
  wire addr_mode_t req_mode = addr_mode_t'(req_spec[`MODE_MSB:`MODE_LSB]);
  wire [2:0] req_reg = req_spec[`REG_MSB:`REG_LSB];
  wire word_t sel_value = regs[req_reg];
  wire word_t pc_value = regs[`PC_NUM];
  wire accept = req_valid && req_ready;
  wire needs_index = (req_mode == AM_INDEX) || (req_mode == AM_INDEXDEF);
  // register deferred needs no read: the register already holds the address
  wire needs_defer = (req_mode == AM_AUTOINCDEF) || (req_mode == AM_AUTODECDEF);
  wire updates_reg = (req_mode == AM_AUTOINC) || (req_mode == AM_AUTOINCDEF) ||
                     (req_mode == AM_AUTODEC) || (req_mode == AM_AUTODECDEF);
  // all address sums wrap at 16 bits
  function automatic word_t wrap_add(input word_t a, input word_t b);
    return 16'(a + b);
  endfunction : wrap_add

  wire index_ack = (state == ST_INDEX) && mem_rd_ack;
  wire defer_ack = (state == ST_DEFER) && mem_rd_ack;
  // relative addressing sees the pc already advanced past the index word
  wire word_t index_sum = wrap_add(mem_rd_data, regs[opnd_reg]);
  wire word_t pc_plus_two = wrap_add(pc_value, `STEP_WORD);
  wire word_t res_old = regs[res_reg];
  wire [7:0] res_old_hi = res_old[15:8];
  wire word_t res_merged = res_byte_move ? {{8{res_data[`BYTE_MSB]}}, res_data[7:0]} :
                           res_byte ? {res_old_hi, res_data[7:0]} : res_data;

  oag_if calc_bus();
  assign calc_bus.mode = req_mode;
  assign calc_bus.reg_num = req_reg;
  assign calc_bus.byte_op = req_byte;
  assign calc_bus.sel_value = sel_value;

  ea_step_unit ea_step_unit_i (
    .bus(calc_bus.calc)
  );

  // one operand at a time, in the order the sequencer offers them
  assign req_ready = (state == ST_IDLE);
  assign done = (state == ST_DONE);
  assign mem_rd_req = (state == ST_INDEX) || (state == ST_DEFER);
  assign rd_data = regs[rd_sel];

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (accept) begin
          next_state = needs_index ? ST_INDEX : needs_defer ? ST_DEFER : ST_DONE;
        end
      end
      ST_INDEX: begin
        if (mem_rd_ack) begin
          next_state = (mode_q == AM_INDEXDEF) ? ST_DEFER : ST_DONE;
        end
      end
      ST_DEFER: begin
        if (mem_rd_ack) begin
          next_state = ST_DONE;
        end
      end
      ST_DONE: begin
        next_state = ST_IDLE;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      mode_q <= AM_REG;
    end else begin
      state <= next_state;
      if (accept) begin
        mode_q <= req_mode;
      end
    end
  end

  // operand result and memory address
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      opnd_is_reg <= 1'b0;
      opnd_reg <= 3'h0;
      opnd_addr <= `REG_RESET;
      mem_addr <= `REG_RESET;
    end else if (accept) begin
      opnd_is_reg <= (req_mode == AM_REG);
      opnd_reg <= req_reg;
      opnd_addr <= calc_bus.pointer;
      mem_addr <= needs_index ? pc_value : calc_bus.pointer;
    end else if (index_ack) begin
      opnd_addr <= index_sum;
      mem_addr <= index_sum;
    end else if (defer_ack) begin
      opnd_addr <= mem_rd_data;
    end
  end

  // register file; address updates override a result write in the same cycle
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < 8; i++) begin
        regs[i] <= `REG_RESET;
      end
    end else begin
      if (res_we) begin
        regs[res_reg] <= res_merged;
      end
      if (pc_step) begin
        regs[`PC_NUM] <= pc_plus_two;
      end
      if (accept && updates_reg) begin
        regs[req_reg] <= calc_bus.next_value;
      end
      if (accept && needs_index) begin
        regs[`PC_NUM] <= pc_plus_two;
      end
    end
  end

  // checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  wire word_t exp_step = (req_byte && req_reg < `SP_NUM) ? `STEP_BYTE : `STEP_WORD;
  wire quiet = !res_we && !pc_step;

  sequence index_fetch_s;
    mem_rd_req && (state == ST_INDEX) && mem_addr == $past(pc_value);
  endsequence

  sequence pc_advanced_s;
    regs[`PC_NUM] == 16'($past(pc_value) + 16'h0002);
  endsequence

  reg_mode_a: assert property (
    accept && req_mode == AM_REG |=> done && opnd_is_reg && !mem_rd_req)
    else $error("register mode did not finish at once without memory");

  byte_low_a: assert property (
    res_we && res_byte && !res_byte_move && !accept && !pc_step
    |=> regs[$past(res_reg)][15:8] == $past(res_old_hi))
    else $error("byte write disturbed high byte");

  sign_ext_a: assert property (
    res_we && res_byte_move && !accept && !pc_step
    |=> regs[$past(res_reg)][15:8] == {8{$past(res_data[7])}})
    else $error("byte move did not sign-extend");

  autoinc_a: assert property (
    accept && req_mode == AM_AUTOINC && quiet
    |=> done && opnd_addr == $past(sel_value) &&
        regs[$past(req_reg)] == 16'($past(sel_value) + $past(exp_step)))
    else $error("autoincrement address or step wrong");

  autodec_a: assert property (
    accept && req_mode == AM_AUTODEC && quiet
    |=> done && opnd_addr == 16'($past(sel_value) - $past(exp_step)))
    else $error("autodecrement address wrong");

  regdef_a: assert property (
    accept && req_mode == AM_REGDEF && quiet
    |=> done && !opnd_is_reg && opnd_addr == $past(sel_value) &&
        regs[$past(req_reg)] == $past(sel_value))
    else $error("register deferred changed register or address");

  index_walk_a: assert property (
    accept && needs_index && quiet |=> index_fetch_s and pc_advanced_s)
    else $error("index word not fetched through advanced pc");

  autoincdef_a: assert property (
    accept && req_mode == AM_AUTOINCDEF && quiet
    |=> mem_rd_req && mem_addr == $past(sel_value) &&
        regs[$past(req_reg)] == 16'($past(sel_value) + 16'h0002))
    else $error("autoincrement deferred pointer or step wrong");

  defer_result_a: assert property (
    defer_ack |=> done && opnd_addr == $past(mem_rd_data))
    else $error("deferred address word not used");
endmodule : operand_address_generator

/* File: test/mem_model.sv */
// word memory model answering the generator's read requests
`timescale 1ns/10ps
module mem_model
  import oag_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // read channel
  input wire logic mem_rd_req,
  input wire word_t mem_addr,
  output logic mem_rd_ack,
  output word_t mem_rd_data,
  // pacing: cycles of wait before each answer
  input wire logic [3:0] wait_n
);
  logic [3:0] cnt;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 4'h0;
      mem_rd_ack <= 1'b0;
      mem_rd_data <= 16'h5a5a;
    end else begin
      // data is only meaningful with the ack, so it toggles otherwise
      mem_rd_data <= ~mem_rd_data;
      mem_rd_ack <= 1'b0;
      // no second ack while the answered request is still visible
      if (mem_rd_req && !mem_rd_ack) begin
        if (cnt == wait_n) begin
          mem_rd_ack <= 1'b1;
          mem_rd_data <= mem_addr + 16'h1000;
          cnt <= 4'h0;
        end else begin
          cnt <= cnt + 4'h1;
        end
      end
    end
  end
endmodule : mem_model

/* File: test/operand_address_generator_tb.sv */
// self-checking bench for the operand address generator
`timescale 1ns/10ps
module operand_address_generator_tb;
  import oag_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic req_valid = 1'b0;
  logic req_ready, done, opnd_is_reg, mem_rd_req, mem_rd_ack;
  logic [5:0] req_spec = 6'h00;
  logic req_byte = 1'b0;
  logic [2:0] opnd_reg;
  word_t opnd_addr, mem_addr, mem_rd_data, rd_data;
  logic res_we = 1'b0;
  logic [2:0] res_reg = 3'h0;
  logic res_byte = 1'b0;
  logic res_byte_move = 1'b0;
  word_t res_data = 16'h0000;
  logic pc_step = 1'b0;
  logic [2:0] rd_sel = 3'h0;
  logic [3:0] wait_n = 4'h0;
  int bad_count = 0;
  int n_compared = 0;

  always #50 core_clk = ~core_clk;

  operand_address_generator operand_address_generator_i (.core_clk(core_clk), .rst_n(rst_n),
    .req_valid(req_valid), .req_ready(req_ready), .req_spec(req_spec), .req_byte(req_byte),
    .done(done), .opnd_is_reg(opnd_is_reg), .opnd_reg(opnd_reg), .opnd_addr(opnd_addr),
    .mem_rd_req(mem_rd_req), .mem_addr(mem_addr), .mem_rd_ack(mem_rd_ack),
    .mem_rd_data(mem_rd_data), .res_we(res_we), .res_reg(res_reg), .res_byte(res_byte),
    .res_byte_move(res_byte_move), .res_data(res_data), .pc_step(pc_step),
    .rd_sel(rd_sel), .rd_data(rd_data));

  mem_model mem_model_i (.core_clk(core_clk), .rst_n(rst_n), .mem_rd_req(mem_rd_req),
    .mem_addr(mem_addr), .mem_rd_ack(mem_rd_ack), .mem_rd_data(mem_rd_data), .wait_n(wait_n));

  task finish_test;
    if (bad_count == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : finish_test

  task chk(input word_t got, input word_t exp);
    n_compared++;
    if (got !== exp) begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      bad_count++;
    end
  endtask : chk

  task getr(input logic [2:0] r, output word_t v);
    rd_sel = r;
    #1 v = rd_data;
  endtask : getr

  task wr(input logic [2:0] r, input logic b, input logic mv, input word_t d);
    @(negedge core_clk);
    res_we = 1'b1;
    res_reg = r;
    res_byte = b;
    res_byte_move = mv;
    res_data = d;
    @(negedge core_clk);
    res_we = 1'b0;
  endtask : wr

  // one operand request, then address and one register compared
  task op(input logic [5:0] s, input logic b, input word_t ea, input logic [2:0] r,
          input word_t rv);
    int i;
    word_t v;
    logic m;
    // modes 3, 5, 6 and 7 read memory right after the take
    m = (s[5:3] == 3'h3) || (s[5:3] >= 3'h5);
    @(negedge core_clk);
    req_valid = 1'b1;
    req_spec = s;
    req_byte = b;
    @(negedge core_clk);
    req_valid = 1'b0;
    chk({14'h0000, req_ready, mem_rd_req}, {14'h0000, 1'b0, m});
    for (i = 0; i < 50 && done !== 1'b1; i++) @(negedge core_clk);
    if (i == 50) begin
      bad_count++;
      finish_test();
    end
    chk(opnd_addr, ea);
    getr(r, v);
    chk(v, rv);
  endtask : op

  task t_reg;
    word_t v;
    wr(3'h3, 1'b0, 1'b0, 16'h1234);
    wr(3'h3, 1'b1, 1'b0, 16'h00ff);
    getr(3'h3, v);
    chk(v, 16'h12ff);
    wr(3'h3, 1'b1, 1'b1, 16'h0080);
    getr(3'h3, v);
    chk(v, 16'hff80);
    op(6'h03, 1'b0, 16'hff80, 3'h3, 16'hff80);
    chk({12'h000, opnd_is_reg, opnd_reg}, 16'h000b);
  endtask : t_reg

  task t_step;
    wr(3'h1, 1'b0, 1'b0, 16'h0100);
    op(6'h11, 1'b1, 16'h0100, 3'h1, 16'h0101);
    op(6'h11, 1'b0, 16'h0101, 3'h1, 16'h0103);
    wr(3'h6, 1'b0, 1'b0, 16'h0200);
    op(6'h16, 1'b1, 16'h0200, 3'h6, 16'h0202);
    wr(3'h0, 1'b0, 1'b0, 16'h0001);
    op(6'h20, 1'b0, 16'hffff, 3'h0, 16'hffff);
    op(6'h20, 1'b1, 16'hfffe, 3'h0, 16'hfffe);
    op(6'h26, 1'b1, 16'h0200, 3'h6, 16'h0200);
  endtask : t_step

  task t_defer;
    wait_n = 4'h3;
    wr(3'h2, 1'b0, 1'b0, 16'h0300);
    op(6'h0a, 1'b0, 16'h0300, 3'h2, 16'h0300);
    op(6'h1a, 1'b1, 16'h1300, 3'h2, 16'h0302);
    op(6'h28, 1'b0, 16'h0ffc, 3'h0, 16'hfffc);
  endtask : t_defer

  task t_index;
    word_t v;
    wait_n = 4'h0;
    wr(3'h7, 1'b0, 1'b0, 16'h0400);
    wr(3'h4, 1'b0, 1'b0, 16'h0010);
    op(6'h34, 1'b0, 16'h1410, 3'h7, 16'h0402);
    getr(3'h4, v);
    chk(v, 16'h0010);
    op(6'h37, 1'b0, 16'h1806, 3'h7, 16'h0404);
    op(6'h3c, 1'b0, 16'h2414, 3'h7, 16'h0406);
    getr(3'h4, v);
    chk(v, 16'h0010);
  endtask : t_index

  task t_pc;
    word_t v;
    op(6'h17, 1'b1, 16'h0406, 3'h7, 16'h0408);
    @(negedge core_clk);
    pc_step = 1'b1;
    @(negedge core_clk);
    pc_step = 1'b0;
    getr(3'h7, v);
    chk(v, 16'h040a);
  endtask : t_pc

  // reset in mid-run, then the first request right after release
  task t_reset;
    word_t v;
    @(negedge core_clk);
    rst_n = 1'b0;
    repeat (3) @(negedge core_clk);
    rst_n = 1'b1;
    chk({12'h000, req_ready, done, mem_rd_req, opnd_is_reg}, 16'h0008);
    chk(opnd_addr, 16'h0000);
    chk(mem_addr, 16'h0000);
    getr(3'h7, v);
    chk(v, 16'h0000);
    op(6'h17, 1'b0, 16'h0000, 3'h7, 16'h0002);
  endtask : t_reset

  initial begin
    repeat (3) @(negedge core_clk);
    rst_n = 1'b1;
    t_reg();
    t_step();
    t_defer();
    t_index();
    t_pc();
    t_reset();
    finish_test();
  end
endmodule : operand_address_generator_tb
